// >>> pkg/xsc_defines.svh
/*
  Offsets, field positions, reset values and timing counts for the
  external synchronous SRAM configuration and access-timing block.
  Assumes inclusion by bare name from the design.
*/
`ifndef XSC_DEFINES_SVH
`define XSC_DEFINES_SVH

`define XSC_OFS_CFG 8'h40
`define XSC_OFS_ADDR 8'h44
`define XSC_OFS_WDATA 8'h48
`define XSC_OFS_WPAR 8'h4C
`define XSC_OFS_CTRL 8'h50
`define XSC_OFS_RDATA 8'h54
`define XSC_OFS_RPAR 8'h58

`define XSC_CFG_RESET 16'h0008
`define XSC_LAT_1 3'h1
`define XSC_LAT_2 3'h2
`define XSC_LAT_3 3'h4
`define XSC_BASE_LINES 5'h0F
`define XSC_ADDR_BANK_BIT 18
`define XSC_CTRL_RD_BIT 0
`define XSC_CTRL_WR_BIT 1
`define XSC_STAT_BUSY_BIT 0
`define XSC_STAT_DONE_BIT 1
`define XSC_TURN_CYCLES 2'h1

`endif

// >>> pkg/xsc_pkg.sv
/*
  Types for the external synchronous SRAM configuration and timing block.
  Assumes nothing of its surroundings.
*/
package xsc_pkg;

  typedef struct packed {
    logic [7:0] upper;
    logic bank_read_turnaround_en;
    logic rw_turnaround_en;
    logic [2:0] read_latency_cycles;
    logic chips_per_bank_select;
    logic [1:0] addr_span_select;
  } xsc_cfg_t;

  typedef struct packed {
    logic [17:0] addr;
    logic [3:0] cs_n;
    logic we_n;
    logic oe_n;
    logic [35:0] dq;
    logic dq_oe;
  } xsc_mem_t;

  typedef enum logic [1:0] {
    XSC_IDLE,
    XSC_TURN,
    XSC_ACT
  } xsc_state_t;

endpackage : xsc_pkg

// >>> src/xsc_ssram_ctrl.sv
/*
  Configuration register and access timing of the external synchronous
  burst SRAM port, reached over an Avalon-MM slave with waitrequest.
  Assumes the SRAM chips run on core_clk_i, so their data needs no
  synchroniser, and a master that holds each request until waitrequest
  is sampled low.
*/
// Contract
// - Span field picks 15 to 18 lines
// - Bit 2 picks one or two chips
// - Latency field sets read sample delay
// - Bit 6 enables read-to-write turnaround
// - Bit 7 enables bank-to-bank read turnaround
// - Configuration resets to 0008 hex
// - Line above span carries bank select, except at the 18-line span, which has no line above it
`timescale 1ns/1ns
`default_nettype none
`include "xsc_defines.svh"

module xsc_ssram_ctrl (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output var xsc_pkg::xsc_mem_t mem_o,
  input wire logic [35:0] mem_dq_i
);

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  // Reserved codes fall back to one cycle; software must avoid them
  function automatic logic [1:0] lat_of(input logic [2:0] code);
    case (code)
      `XSC_LAT_2: lat_of = 2'h2;
      `XSC_LAT_3: lat_of = 2'h3;
      default: lat_of = 2'h1;
    endcase
  endfunction : lat_of

  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        m[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    merge = m;
  endfunction : merge

  // Lines at and above the span's top are zero, except the bank select
  function automatic logic [17:0] line_map(input logic [17:0] word,
      input logic bank, input logic [1:0] span);
    logic [17:0] a;
    logic [4:0] top;
    a = 18'h00000;
    top = `XSC_BASE_LINES + {3'h0, span};
    for (int i = 0; i < 18; i++) begin
      if (5'(i) < top) begin
        a[i] = word[i];
      end else if (5'(i) == top) begin
        a[i] = bank;
      end
    end
    line_map = a;
  endfunction : line_map

  // One chip per bank uses only the first chip of the pair
  function automatic logic [3:0] cs_of(input logic bank, input logic two);
    logic [1:0] pair;
    pair = two ? 2'h3 : 2'h1;
    cs_of = bank ? ~{pair, 2'h0} : ~{2'h0, pair};
  endfunction : cs_of

  ////////////////////////////////////////////////////////////////////////
  // Registers

  logic [15:0] cfg_r;
  logic [18:0] addr_r;
  logic [31:0] wdata_r;
  logic [3:0] wpar_r;
  logic [35:0] rdata_r;
  logic done_r;
  logic wait_r;
  logic [31:0] rd_nxt;
  xsc_pkg::xsc_cfg_t cfg;
  xsc_pkg::xsc_state_t state_r;
  logic pend_rd_r;
  logic [1:0] cnt_r;
  logic last_rd_r;
  logic last_bank_r;
  logic bus_req;
  logic bus_do;
  logic start_rd;
  logic start_wr;
  logic done_set;
  logic done_clr;
  logic op_bank;
  logic need_turn;
  logic launch;
  logic launch_rd;

  assign cfg = xsc_pkg::xsc_cfg_t'(cfg_r);
  assign bus_req = avs_read_i | avs_write_i;
  assign bus_do = bus_req & ~wait_r;
  assign op_bank = addr_r[`XSC_ADDR_BANK_BIT];

  ////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave: one wait cycle, then the access completes

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      wait_r <= 1'b1;
    end else begin
      wait_r <= ~(bus_req & wait_r);
    end
  end

  always_comb begin
    rd_nxt = 32'h00000000;
    case (avs_address_i)
      `XSC_OFS_CFG: rd_nxt = {16'h0000, cfg_r};
      `XSC_OFS_ADDR: rd_nxt = {13'h0000, addr_r};
      `XSC_OFS_WDATA: rd_nxt = wdata_r;
      `XSC_OFS_WPAR: rd_nxt = {28'h0000000, wpar_r};
      `XSC_OFS_CTRL: rd_nxt = {30'h00000000, done_r, state_r != xsc_pkg::XSC_IDLE};
      `XSC_OFS_RDATA: rd_nxt = rdata_r[31:0];
      `XSC_OFS_RPAR: rd_nxt = {28'h0000000, rdata_r[35:32]};
      default: rd_nxt = 32'h00000000;
    endcase
  end

  // Latched when the request is first seen, so it stands through the answer cycle
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      avs_readdata_o <= 32'h00000000;
    end else if (avs_read_i & wait_r) begin
      avs_readdata_o <= rd_nxt;
    end
  end

  // Upper bits are stored as written; keeping them zero is software's job
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      cfg_r <= `XSC_CFG_RESET;
    end else if (bus_do & avs_write_i & (avs_address_i == `XSC_OFS_CFG)) begin
      cfg_r <= 16'(merge({16'h0000, cfg_r}, avs_writedata_i, avs_byteenable_i));
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      addr_r <= 19'h00000;
      wdata_r <= 32'h00000000;
      wpar_r <= 4'h0;
    end else if (bus_do & avs_write_i) begin
      case (avs_address_i)
        `XSC_OFS_ADDR: addr_r <= 19'(merge({13'h0000, addr_r}, avs_writedata_i, avs_byteenable_i));
        `XSC_OFS_WDATA: wdata_r <= merge(wdata_r, avs_writedata_i, avs_byteenable_i);
        `XSC_OFS_WPAR: wpar_r <= 4'(merge({28'h0000000, wpar_r}, avs_writedata_i, avs_byteenable_i));
        default: ;
      endcase
    end
  end

  // Start bits are ignored while an access is in flight
  assign start_rd = bus_do & avs_write_i & (avs_address_i == `XSC_OFS_CTRL) & avs_byteenable_i[0]
    & avs_writedata_i[`XSC_CTRL_RD_BIT] & (state_r == xsc_pkg::XSC_IDLE);
  assign start_wr = bus_do & avs_write_i & (avs_address_i == `XSC_OFS_CTRL) & avs_byteenable_i[0]
    & avs_writedata_i[`XSC_CTRL_WR_BIT] & ~avs_writedata_i[`XSC_CTRL_RD_BIT]
    & (state_r == xsc_pkg::XSC_IDLE);
  assign done_clr = bus_do & avs_write_i & (avs_address_i == `XSC_OFS_CTRL) & avs_byteenable_i[0]
    & avs_writedata_i[`XSC_STAT_DONE_BIT];

  // A completion in the clearing cycle wins
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      done_r <= 1'b0;
    end else if (done_set) begin
      done_r <= 1'b1;
    end else if (done_clr) begin
      done_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Memory access sequencer

  // Only a read can leave the chips driving the data lines, so only a read earns a turnaround
  assign need_turn = last_rd_r & ((start_wr & cfg.rw_turnaround_en)
    | (start_rd & cfg.bank_read_turnaround_en & (op_bank != last_bank_r)));
  assign done_set = (state_r == xsc_pkg::XSC_ACT)
    & (~pend_rd_r | ((cnt_r + 2'h1) == lat_of(cfg.read_latency_cycles)));
  // A launch comes straight from idle, or one cycle later after a turnaround
  assign launch = ((state_r == xsc_pkg::XSC_IDLE) & (start_rd | start_wr) & ~need_turn)
    | (state_r == xsc_pkg::XSC_TURN);
  assign launch_rd = (state_r == xsc_pkg::XSC_TURN) ? pend_rd_r : start_rd;

  // The request kind is kept across the turnaround cycle
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      state_r <= xsc_pkg::XSC_IDLE;
      pend_rd_r <= 1'b0;
    end else begin
      case (state_r)
        xsc_pkg::XSC_IDLE: begin
          if (start_rd | start_wr) begin
            pend_rd_r <= start_rd;
            if (need_turn) begin
              state_r <= xsc_pkg::XSC_TURN;
            end else begin
              state_r <= xsc_pkg::XSC_ACT;
            end
          end
        end
        xsc_pkg::XSC_TURN: begin
          // Bus stays released for one cycle before the launch
          state_r <= xsc_pkg::XSC_ACT;
        end
        xsc_pkg::XSC_ACT: begin
          if (done_set) begin
            state_r <= xsc_pkg::XSC_IDLE;
          end
        end
        default: state_r <= xsc_pkg::XSC_IDLE;
      endcase
    end
  end

  // Counts cycles since the launch; idle and turnaround hold it at zero
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      cnt_r <= 2'h0;
    end else if (state_r == xsc_pkg::XSC_ACT) begin
      cnt_r <= cnt_r + 2'h1;
    end else begin
      cnt_r <= 2'h0;
    end
  end

  // Strobes stand one cycle; read enable stays low until the capture edge
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      mem_o.addr <= 18'h00000;
      mem_o.cs_n <= 4'hF;
      mem_o.we_n <= 1'b1;
      mem_o.oe_n <= 1'b1;
      mem_o.dq <= 36'h000000000;
      mem_o.dq_oe <= 1'b0;
    end else if (launch) begin
      mem_o.addr <= line_map(addr_r[17:0], op_bank, cfg.addr_span_select);
      mem_o.cs_n <= cs_of(op_bank, cfg.chips_per_bank_select);
      mem_o.we_n <= launch_rd;
      mem_o.oe_n <= ~launch_rd;
      mem_o.dq <= {wpar_r, wdata_r};
      mem_o.dq_oe <= ~launch_rd;
    end else if (state_r == xsc_pkg::XSC_ACT) begin
      mem_o.cs_n <= 4'hF;
      mem_o.we_n <= 1'b1;
      mem_o.dq_oe <= 1'b0;
      if (done_set) begin
        mem_o.oe_n <= 1'b1;
      end
    end
  end

  // A reserved latency code is sampled as if it were one cycle
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      rdata_r <= 36'h000000000;
    end else if (done_set & pend_rd_r) begin
      rdata_r <= mem_dq_i;
    end
  end

  // Remembers the last access so the next one can decide on a turnaround
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      last_rd_r <= 1'b0;
      last_bank_r <= 1'b0;
    end else if (done_set) begin
      last_rd_r <= pend_rd_r;
      last_bank_r <= op_bank;
    end
  end

  assign avs_waitrequest_o = wait_r;

endmodule : xsc_ssram_ctrl
`default_nettype wire

// >>> bench/xsc_ssram_checker.sv
/* Port assertions for the SSRAM block.
   Assumes bind to xsc_ssram_ctrl and full-word config writes. */
`timescale 1ns/1ns
`default_nettype none
module xsc_ssram_checker (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic avs_waitrequest_o,
  input wire xsc_pkg::xsc_mem_t mem_o
);
  logic [15:0] cfg_r;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  // Shadow config, since the checker cannot see the register
  always_ff @(posedge core_clk_i) begin
    if (srst_i)
      cfg_r <= 16'h0008;
    else if (avs_write_i && !avs_waitrequest_o && avs_address_i == 8'h40)
      cfg_r <= avs_writedata_i[15:0];
  end
  //////////
  property p_span; mem_o.cs_n != 4'hF && cfg_r[1:0] == 2'h0 |-> mem_o.addr[17:16] == 2'h0;
  endproperty
  a_span: assert property (p_span) else $error("lines above span driven");
  property p_chip; mem_o.cs_n != 4'hF |-> (cfg_r[2] ? mem_o.cs_n inside {4'hC, 4'h3} : mem_o.cs_n inside {4'hE, 4'hB});
  endproperty
  a_chip: assert property (p_chip) else $error("wrong chip selects");
  property p_lat2; $fell(mem_o.oe_n) && cfg_r[5:3] == 3'h2 |=> !mem_o.oe_n ##1 mem_o.oe_n;
  endproperty
  a_lat2: assert property (p_lat2) else $error("read enable not two cycles");
  property p_lat3; $fell(mem_o.oe_n) && cfg_r[5:3] == 3'h4 |=> !mem_o.oe_n [*2] ##1 mem_o.oe_n;
  endproperty
  a_lat3: assert property (p_lat3) else $error("read enable not three cycles");
  property p_rst; disable iff (1'b0) srst_i |=> avs_waitrequest_o && mem_o.cs_n == 4'hF && !mem_o.dq_oe;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not idle after reset");
  property p_rel; mem_o.dq_oe |-> !mem_o.we_n && mem_o.oe_n;
  endproperty
  a_rel: assert property (p_rel) else $error("data driven outside write");
  property p_wr1; $fell(mem_o.we_n) |=> mem_o.we_n && mem_o.cs_n == 4'hF && !mem_o.dq_oe;
  endproperty
  a_wr1: assert property (p_wr1) else $error("write not one cycle");
  property p_wait; !avs_waitrequest_o |=> avs_waitrequest_o;
  endproperty
  a_wait: assert property (p_wait) else $error("waitrequest low twice");
  c_lat3: cover property ($fell(mem_o.oe_n) && cfg_r[5:3] == 3'h4);
  c_turn: cover property ($fell(mem_o.we_n) && cfg_r[6]);
  c_pair: cover property (mem_o.cs_n == 4'h3);
endmodule : xsc_ssram_checker
`default_nettype wire

// >>> bench/xsc_sram_model.sv
/* Behavioural burst SRAM on the memory port.
   Assumes the controller clock and word addresses below 16. */
`timescale 1ns/1ns
`default_nettype none
module xsc_sram_model (
  input wire logic clk_i,
  input wire xsc_pkg::xsc_mem_t mem_i,
  output logic [35:0] dq_o
);
  logic [35:0] arr [16];
  always @(posedge clk_i) begin
    if (mem_i.cs_n != 4'hF && !mem_i.we_n)
      arr[mem_i.addr[3:0]] <= mem_i.dq;
  end
  // Word stands while read is enabled; a released bus shows its inverse, so stale data never match
  assign dq_o = mem_i.oe_n ? ~arr[mem_i.addr[3:0]] : arr[mem_i.addr[3:0]];
endmodule : xsc_sram_model
`default_nettype wire

// >>> bench/xsc_ssram_ctrl_tb_top.sv
/* Top testbench for the SSRAM block.
   Assumes the bus map and timing of the design hand-over. */
`timescale 1ns/1ns
`default_nettype none
module xsc_ssram_ctrl_tb_top;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdat, v, c, d;
  logic wreq, cpb;
  logic [35:0] dq;
  xsc_pkg::xsc_mem_t mem;
  logic [17:0] la;
  logic [3:0] lc;
  logic [3:0] pcs = 4'hF;
  logic [2:0] lat [3] = '{3'h1, 3'h2, 3'h4};
  logic [7:0] tcfg [5] = '{8'h48, 8'h08, 8'h88, 8'h88, 8'h48};
  logic [1:0] tctl [5] = '{2'h2, 2'h2, 2'h1, 2'h1, 2'h1};
  logic tbk [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
  int tgap [5] = '{2, 1, 2, 1, 1};
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0;
  int t0, lg, s, w, e;
  always #10 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  xsc_ssram_ctrl dut_u (.core_clk_i(clk), .srst_i(srst), .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wd), .avs_byteenable_i(4'hF), .avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
    .mem_o(mem), .mem_dq_i(dq));
  xsc_sram_model mdl_u (.clk_i(clk), .mem_i(mem), .dq_o(dq));
  // Launch gap is counted from the edge where waitrequest drops for the start write, one edge before it lands
  always @(negedge clk) begin
    if (mem.cs_n !== 4'hF && pcs === 4'hF) begin
      lg = cyc - t0;
      la = mem.addr;
      lc = mem.cs_n;
    end
    pcs = mem.cs_n;
  end
  //////////
  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  always @(posedge clk) if (cyc == 20000) begin
    error_cnt++;
    complete_run();
  end
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    checks_done++;
    if (g !== x) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  task automatic bus(input logic wn, input logic [7:0] a, input logic [31:0] dd);
    int n;
    n = 0;
    @(posedge clk);
    rd <= !wn;
    wr <= wn;
    adr <= a;
    wd <= dd;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    if (n == 50)
      error_cnt++;
    v = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic op(input logic [31:0] cc);
    bus(1'b1, 8'h50, cc);
    t0 = cyc;
    v = 32'h1;
    for (int i = 0; i < 20 && v[0] !== 1'b0; i++)
      bus(1'b0, 8'h50, 32'h0);
  endtask : op
  //////////
  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    bus(1'b0, 8'h40, 32'h0);
    chk("cfg reset", 32'h0000_0008, v);
    bus(1'b1, 8'h7C, 32'hFFFF_FFFF);
    bus(1'b0, 8'h7C, 32'h0);
    chk("unmapped", 32'h0, v);
    for (int i = 0; i < 12; i++) begin
      s = i / 3;
      cpb = i[0];
      w = 32'h0003_FFF0 + i;
      c = {26'h0, lat[i % 3], cpb, s[1:0]};
      d = 32'h5A3C_0000 + w;
      e = (w & ((1 << (15 + s)) - 1)) | ((s < 3) ? (1 << (15 + s)) : 0);
      bus(1'b1, 8'h40, c);
      bus(1'b0, 8'h40, 32'h0);
      chk("cfg", c, v);
      bus(1'b1, 8'h44, {13'h0, 1'b1, w[17:0]});
      bus(1'b1, 8'h48, d);
      bus(1'b1, 8'h4C, {28'h0, i[3:0]});
      op(32'h2);
      chk("done", 32'h0000_0002, v);
      chk("addr lines", e, {14'h0, la});
      chk("chip sel", cpb ? 4'h3 : 4'hB, lc);
      op(32'h1);
      bus(1'b0, 8'h54, 32'h0);
      chk("rdata", d, v);
      bus(1'b0, 8'h58, 32'h0);
      chk("rpar", {28'h0, i[3:0]}, v);
    end
    for (int k = 0; k < 5; k++) begin
      bus(1'b1, 8'h40, {24'h0, tcfg[k]});
      bus(1'b1, 8'h44, 32'h0004_0001);
      op(32'h1);
      bus(1'b1, 8'h44, {13'h0, tbk[k], 18'h00001});
      op({30'h0, tctl[k]});
      chk("launch gap", tgap[k], lg);
    end
    complete_run();
  end
endmodule : xsc_ssram_ctrl_tb_top
bind xsc_ssram_ctrl xsc_ssram_checker chk_u (.core_clk_i(core_clk_i), .srst_i(srst_i),
  .avs_address_i(avs_address_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_waitrequest_o(avs_waitrequest_o), .mem_o(mem_o));
`default_nettype wire
